// ===== design/eepc_pkg.sv
package eepc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte addresses (low 16 bits, upper bits must be zero)
    localparam logic [15:0] NVCFG_ADDR = 16'hfe1c;
    localparam logic [15:0] CTRL_ADDR = 16'hfe20;
    localparam logic [15:0] VCFG_ADDR = 16'hfe24;
    // array window: one word per array byte
    localparam logic [15:0] ARR_BASE = 16'h2000;
    localparam logic [15:0] ARR_LAST = 16'h27fc;

    ////////////////////////////////////////////////////////////////////////////
    // array geometry
    localparam int ARR_AW = 9;
    localparam int BLK_SHIFT = 7;
    localparam int BLK_COUNT = 4;
    localparam logic [8:0] SEC_LO = 9'h0f0;
    localparam logic [8:0] SEC_HI = 9'h0ff;

    ////////////////////////////////////////////////////////////////////////////
    // control register fields
    localparam int CTRL_PGM_BIT = 0;
    localparam int CTRL_LAT_BIT = 1;
    localparam int CTRL_PWRDN_BIT = 2;
    localparam int CTRL_RAS0_BIT = 4;
    localparam int CTRL_RAS1_BIT = 5;

    // configuration byte fields
    localparam int CFG_BP_LSB = 0;
    localparam int CFG_BP_MSB = 3;
    localparam int CFG_SEC_BIT = 4;
    localparam int CFG_RA_BIT = 7;

    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        MODE_PROG = 2'b00,
        MODE_BYTE_ERASE = 2'b01,
        MODE_BLOCK_ERASE = 2'b10,
        MODE_BULK_ERASE = 2'b11
    } eepc_mode_e;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_WRITE = 3'b010,
        PH_RWAIT = 3'b100
    } eepc_phase_e;

    typedef struct packed {
        eepc_phase_e ph;
        logic [15:0] ph_addr;
        logic ph_ok;
        logic hready;
        logic hresp;
        logic [31:0] hrdata;
        logic pgm;
        logic lat;
        logic pwrdn;
        eepc_mode_e mode;
        logic [7:0] shadow;
        logic loaded;
        logic valid_wr;
        logic [8:0] tgt_addr;
        logic tgt_nv;
        logic [7:0] tgt_data;
        logic hv;
        logic [8:0] raddr;
    } eepc_state_s;

    localparam eepc_state_s ST_RST = '{
        ph: PH_IDLE,
        ph_addr: 16'h0000,
        ph_ok: 1'b0,
        hready: 1'b1,
        hresp: 1'b0,
        hrdata: 32'h0000_0000,
        pgm: 1'b0,
        lat: 1'b0,
        pwrdn: 1'b0,
        mode: MODE_PROG,
        shadow: 8'hff,
        loaded: 1'b0,
        valid_wr: 1'b0,
        tgt_addr: 9'h000,
        tgt_nv: 1'b0,
        tgt_data: 8'h00,
        hv: 1'b0,
        raddr: 9'h000
    };

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic is_arr(input logic [15:0] a);
        return (a >= ARR_BASE) && (a <= ARR_LAST) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic [8:0] arr_idx(input logic [15:0] a);
        return a[10:2];
    endfunction

    function automatic logic [1:0] blk_of(input logic [8:0] i);
        return i[8:7];
    endfunction

    function automatic logic in_sec(input logic [8:0] i);
        return (i >= SEC_LO) && (i <= SEC_HI);
    endfunction

endpackage

// ===== design/eepc_guard.sv
`timescale 1ns/1ns
`default_nettype none
module eepc_guard (
    input wire eepc_pkg::eepc_mode_e mode,
    input wire logic [8:0] tgt_addr,
    input wire logic tgt_nv,
    input wire logic [3:0] protect,
    input wire logic secure,
    output logic allowed
);
    import eepc_pkg::*;

    logic blk_ok;

    always_comb begin
        blk_ok = !protect[blk_of(tgt_addr)];
        case (mode)
            MODE_PROG, MODE_BYTE_ERASE: begin
                if (tgt_nv) begin
                    allowed = !secure;
                end else begin
                    allowed = blk_ok && !(secure && in_sec(tgt_addr));
                end
            end
            MODE_BLOCK_ERASE: begin
                allowed = !tgt_nv && blk_ok && !secure;
            end
            MODE_BULK_ERASE: begin
                allowed = !tgt_nv && (protect == 4'h0) && !secure;
            end
            default: begin
                allowed = 1'b0;
            end
        endcase
    end

endmodule // eepc_guard
`default_nettype wire

// ===== design/eepc_ctrl.sv
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module eepc_ctrl (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [7:0] arr_rdata,
    input wire logic [7:0] nv_cfg,
    input wire logic stop_mode,
    output logic [8:0] arr_raddr,
    output logic [8:0] prog_addr,
    output logic prog_nv,
    output logic [7:0] prog_data,
    output eepc_pkg::eepc_mode_e prog_mode,
    output logic hv_on,
    output logic array_off,
    output logic bus_latched
);
    import eepc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state
    eepc_state_s r;
    eepc_state_s next_r;

    logic secure;
    logic allowed;
    logic accept;
    logic [7:0] wd;
    logic [7:0] rd_byte;
    logic [8:0] widx;
    logic size_ok;
    eepc_mode_e mode_now;

    assign secure = !r.shadow[CFG_SEC_BIT];

    // mode as it stands after this cycle's write, so the pump never sees a stale mode
    assign mode_now = ((r.ph == PH_WRITE) && r.ph_ok && (r.ph_addr == CTRL_ADDR) && !r.pgm)
        ? eepc_mode_e'(hwdata[CTRL_RAS1_BIT:CTRL_RAS0_BIT]) : r.mode;

    ////////////////////////////////////////////////////////////////////////////
    // permission check on the latched target
    eepc_guard u_guard (
        .mode(mode_now),
        .tgt_addr(r.tgt_addr),
        .tgt_nv(r.tgt_nv),
        .protect(r.shadow[CFG_BP_MSB:CFG_BP_LSB]),
        .secure(secure),
        .allowed(allowed)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read data selection
    always_comb begin
        rd_byte = 8'h00;
        if (r.ph_ok) begin
            if (r.ph_addr == CTRL_ADDR) begin
                rd_byte[CTRL_PGM_BIT] = r.pgm;
                rd_byte[CTRL_LAT_BIT] = r.lat;
                rd_byte[CTRL_PWRDN_BIT] = r.pwrdn;
                rd_byte[CTRL_RAS0_BIT] = r.mode[0];
                rd_byte[CTRL_RAS1_BIT] = r.mode[1];
            end else if (r.ph_addr == VCFG_ADDR) begin
                rd_byte = r.shadow;
            end else if (r.ph_addr == NVCFG_ADDR) begin
                rd_byte = nv_cfg;
            end else if (is_arr(r.ph_addr)) begin
                // latched data replaces array data while the buses are latched
                rd_byte = r.lat ? r.tgt_data : arr_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_r = r;
        wd = hwdata[7:0];
        widx = arr_idx(r.ph_addr);
        size_ok = (hsize == 3'b010);
        accept = hsel && htrans[1] && hready && (r.ph != PH_RWAIT);
        next_r.ph = PH_IDLE;
        next_r.hresp = 1'b0;

        case (r.ph)
            PH_WRITE: begin
                if (r.ph_ok && (r.ph_addr == CTRL_ADDR)) begin
                    // mode is frozen once the enable is set
                    next_r.mode = mode_now;
                    next_r.pwrdn = wd[CTRL_PWRDN_BIT];
                    if (wd[CTRL_PGM_BIT]) begin
                        next_r.pgm = r.pgm | (r.lat && r.valid_wr);
                    end else begin
                        next_r.pgm = 1'b0;
                    end
                    // latch stays while the enable is or becomes set
                    next_r.lat = wd[CTRL_LAT_BIT] | r.pgm | next_r.pgm;
                    if (!r.lat || !next_r.lat) begin
                        next_r.valid_wr = 1'b0;
                    end
                end else if (r.ph_ok && (r.ph_addr == VCFG_ADDR)) begin
                    // a write cannot disarm an armed security bit; a read of NVCFG_ADDR reloads it from nv_cfg
                    next_r.shadow = {wd[7:5], wd[CFG_SEC_BIT] & r.shadow[CFG_SEC_BIT], wd[3:0]};
                end else if (r.ph_ok && (r.ph_addr == NVCFG_ADDR)) begin
                    if (r.lat && !r.pgm && !secure) begin
                        next_r.tgt_nv = 1'b1;
                        next_r.tgt_data = wd;
                        next_r.valid_wr = 1'b1;
                    end
                end else if (r.ph_ok && is_arr(r.ph_addr)) begin
                    if (r.lat && !r.pgm && !(secure && in_sec(widx))) begin
                        next_r.tgt_nv = 1'b0;
                        next_r.tgt_addr = widx;
                        next_r.tgt_data = wd;
                        next_r.valid_wr = 1'b1;
                    end
                end
            end
            PH_RWAIT: begin
                next_r.hrdata = {24'h000000, rd_byte};
                next_r.hready = 1'b1;
                if (r.ph_ok && (r.ph_addr == NVCFG_ADDR)) begin
                    next_r.shadow = nv_cfg;
                end
            end
            default: begin
            end
        endcase

        ////////////////////////////////////////////////////////////////////////
        // address phase
        if (accept) begin
            next_r.ph_addr = haddr[15:0];
            next_r.ph_ok = (haddr[31:16] == 16'h0000) && size_ok;
            if (hwrite) begin
                next_r.ph = PH_WRITE;
            end else begin
                next_r.ph = PH_RWAIT;
                next_r.hready = 1'b0;
                next_r.raddr = arr_idx(haddr[15:0]);
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // shadow load after reset release
        if (!r.loaded) begin
            next_r.shadow = nv_cfg;
            next_r.loaded = 1'b1;
        end

        ////////////////////////////////////////////////////////////////////////
        // pump: off in stop, back on after stop; wait mode has no effect
        next_r.hv = next_r.pgm && !stop_mode && allowed && r.loaded;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= ST_RST;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign hreadyout = r.hready;
    assign hresp = r.hresp;
    assign hrdata = r.hrdata;
    assign arr_raddr = r.raddr;
    assign prog_addr = r.tgt_addr;
    assign prog_nv = r.tgt_nv;
    assign prog_data = r.tgt_data;
    assign prog_mode = r.mode;
    assign hv_on = r.hv;
    assign array_off = r.pwrdn;
    assign bus_latched = r.lat;

endmodule // eepc_ctrl
`default_nettype wire

// ===== verif/eepc_properties.sv
`timescale 1ns/1ns
`default_nettype none
module eepc_properties (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hreadyout,
    input wire logic stop_mode,
    input wire logic hv_on,
    input wire logic bus_latched,
    input wire eepc_pkg::eepc_mode_e prog_mode
);
    import eepc_pkg::*;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic take;
    assign take = hsel & htrans[1] & hreadyout;
    sequence s_stop_quiet;
        (stop_mode && !hsel) [*4];
    endsequence
    sequence s_resume;
        !stop_mode && !hsel;
    endsequence
    a_reset_clear: assert property ($rose(hresetn) |-> !bus_latched && !hv_on && prog_mode == MODE_PROG)
        else $error("control bits not cleared by reset");
    a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait cycle wrong");
    a_write_nowait: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    a_hv_latch: assert property (hv_on |-> bus_latched)
        else $error("pump on without latch");
    a_latch_held: assert property ($fell(bus_latched) |-> !hv_on)
        else $error("latch cleared with pump on");
    a_hv_cause: assert property ($rose(hv_on) |-> bus_latched && !$past(stop_mode))
        else $error("pump rose without cause");
    a_stop_drop: assert property (stop_mode |=> !hv_on)
        else $error("pump on in stop");
    a_stop_resume: assert property (hv_on && !hsel ##1 s_stop_quiet ##1 s_resume |=> hv_on)
        else $error("pump not restored after stop");
    a_mode_frozen: assert property (hv_on |=> $stable(prog_mode))
        else $error("mode changed with pump on");
endmodule // eepc_properties
`default_nettype wire

// ===== verif/eepc_array_model.sv
`timescale 1ns/1ns
`default_nettype none
module eepc_array_model #(
    parameter logic [7:0] NV = 8'h72
) (
    input wire logic hclk,
    input wire logic [8:0] arr_raddr,
    input wire logic [8:0] prog_addr,
    input wire logic prog_nv,
    input wire logic [7:0] prog_data,
    input wire eepc_pkg::eepc_mode_e prog_mode,
    input wire logic hv_on,
    output logic [7:0] arr_rdata,
    output logic [7:0] nv_cfg
);
    import eepc_pkg::*;
    logic [7:0] mem [512];
    initial begin
        for (int i = 0; i < 512; i++) mem[i] = ~i[7:0];
    end
    // programmed byte, redundant bit kept at zero
    assign nv_cfg = NV;
    assign arr_rdata = mem[arr_raddr];
    // programming only clears bits
    always @(posedge hclk) begin
        if (hv_on && prog_mode == MODE_PROG && !prog_nv) begin
            mem[prog_addr] <= mem[prog_addr] & prog_data;
        end
    end
endmodule // eepc_array_model
`default_nettype wire

// ===== verif/test_eeprom_program_erase_control.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module test_eeprom_program_erase_control;
    import eepc_pkg::*;
    localparam logic [7:0] NV = 8'h72;
    // stop recovery interval in cycles, arbitrary bench value
    localparam int STOP_RECOVERY = 8;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, stop_mode = 0;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic hreadyout, hresp, prog_nv, hv_on, bus_latched, array_off;
    logic [7:0] arr_rdata, nv_cfg, prog_data;
    logic [8:0] arr_raddr, prog_addr;
    eepc_mode_e prog_mode;
    int n_fail = 0, n_compared = 0;
    always #4 hclk = ~hclk;
    eepc_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .arr_rdata(arr_rdata), .nv_cfg(nv_cfg), .stop_mode(stop_mode),
        .arr_raddr(arr_raddr), .prog_addr(prog_addr), .prog_nv(prog_nv), .prog_data(prog_data),
        .prog_mode(prog_mode), .hv_on(hv_on), .array_off(array_off), .bus_latched(bus_latched));
    eepc_array_model #(.NV(NV)) u_mem (.hclk(hclk), .arr_raddr(arr_raddr), .prog_addr(prog_addr),
        .prog_nv(prog_nv), .prog_data(prog_data), .prog_mode(prog_mode), .hv_on(hv_on),
        .arr_rdata(arr_rdata), .nv_cfg(nv_cfg));
    ////////////////////////////////////////////////////////////////////////////
    task test_done;
        $display("checks %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task wt;
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 40);
        if (hreadyout !== 1'b1) begin
            n_fail++;
            test_done;
        end
    endtask
    task xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= {16'h0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        wt;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h000000, d};
        wt;
        r = hrdata;
        @(posedge hclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(0, CTRL_ADDR, 0); `CHK("ctrl", 32'h0, r)
        xfer(0, VCFG_ADDR, 0); `CHK("vcfg", {24'h0, NV}, r)
        xfer(0, NVCFG_ADDR, 0); `CHK("nvcfg", {24'h0, NV}, r)
        xfer(0, 16'h0100, 0); `CHK("unmapped", 32'h0, r)
        xfer(0, ARR_BASE + 16'd28, 0); `CHK("array", 32'h0f8, r)
        `CHK("hresp", 1'b0, hresp)
        xfer(1, CTRL_ADDR, 8'h04); `CHK("pwrdn", 1'b1, array_off)
        xfer(0, CTRL_ADDR, 0); `CHK("ctrl pwrdn", 32'h04, r)
        xfer(1, CTRL_ADDR, 8'h00); `CHK("pwrup", 1'b0, array_off)
        for (int m = 1; m < 4; m++) begin
            xfer(1, CTRL_ADDR, 8'h02 | 8'(m << 4)); `CHK("mode", 2'(m), prog_mode)
        end
        xfer(1, CTRL_ADDR, 8'h00);
        xfer(1, CTRL_ADDR, 8'h02);
        xfer(1, ARR_BASE + 16'd20, 8'ha5); `CHK("paddr", 9'd5, prog_addr)
        `CHK("pdata", 8'ha5, prog_data)
        xfer(0, ARR_BASE + 16'd28, 0); `CHK("latched rd", 32'h0a5, r)
        xfer(1, CTRL_ADDR, 8'h03); `CHK("hv", 1'b1, hv_on)
        stop_mode <= 1'b1;
        repeat (2) @(posedge hclk); `CHK("hv stop", 1'b0, hv_on)
        repeat (2) @(posedge hclk);
        stop_mode <= 1'b0;
        repeat (2) @(posedge hclk); `CHK("hv back", 1'b1, hv_on)
        repeat (STOP_RECOVERY) @(posedge hclk);
        xfer(1, CTRL_ADDR, 8'h00); `CHK("hv off", 1'b0, hv_on)
        `CHK("latch kept", 1'b1, bus_latched)
        stop_mode <= 1'b1;
        repeat (3) @(posedge hclk);
        stop_mode <= 1'b0;
        repeat (STOP_RECOVERY) @(posedge hclk);
        `CHK("hv stop idle", 1'b0, hv_on)
        xfer(1, CTRL_ADDR, 8'h00); `CHK("latch off", 1'b0, bus_latched)
        xfer(0, ARR_BASE + 16'd20, 0); `CHK("prog", {24'h0, 8'hfa & 8'ha5}, r)
        xfer(1, CTRL_ADDR, 8'h02);
        xfer(1, ARR_BASE + 16'd520, 8'h11);
        xfer(1, CTRL_ADDR, 8'h03); `CHK("hv prot", 1'b0, hv_on)
        xfer(1, CTRL_ADDR, 8'h00);
        xfer(1, CTRL_ADDR, 8'h00);
        xfer(1, CTRL_ADDR, 8'h02);
        xfer(1, VCFG_ADDR, NV);
        xfer(1, CTRL_ADDR, 8'h03); `CHK("hv seq", 1'b0, hv_on)
        xfer(0, CTRL_ADDR, 0); `CHK("ctrl seq", 32'h02, r)
        xfer(1, CTRL_ADDR, 8'h00);
        xfer(1, CTRL_ADDR, 8'h00);
        xfer(1, VCFG_ADDR, 8'h60);
        xfer(0, VCFG_ADDR, 0); `CHK("vcfg sec", 32'h60, r)
        xfer(1, CTRL_ADDR, 8'h12);
        xfer(1, ARR_BASE + 16'h0040, 8'h44);
        xfer(1, CTRL_ADDR, 8'h13); `CHK("hv byte erase", 1'b1, hv_on)
        xfer(1, CTRL_ADDR, 8'h10);
        xfer(1, CTRL_ADDR, 8'h00);
        xfer(1, CTRL_ADDR, 8'h22);
        xfer(1, ARR_BASE + 16'h0040, 8'h44);
        xfer(1, CTRL_ADDR, 8'h23); `CHK("hv block sec", 1'b0, hv_on)
        xfer(1, CTRL_ADDR, 8'h20);
        xfer(1, CTRL_ADDR, 8'h00);
        xfer(1, CTRL_ADDR, 8'h02);
        xfer(1, ARR_BASE + 16'h03c0, 8'h33); `CHK("sec latch", 8'h44, prog_data)
        xfer(1, CTRL_ADDR, 8'h03);
        xfer(0, CTRL_ADDR, 0); `CHK("ctrl sec", 32'h02, r)
        xfer(1, CTRL_ADDR, 8'h00);
        xfer(1, VCFG_ADDR, 8'h7f);
        xfer(0, VCFG_ADDR, 0); `CHK("vcfg wr", 32'h6f, r)
        xfer(0, NVCFG_ADDR, 0);
        xfer(0, VCFG_ADDR, 0); `CHK("vcfg reload", {24'h0, NV}, r)
        test_done;
    end
endmodule // test_eeprom_program_erase_control
bind eepc_ctrl eepc_properties u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hreadyout(hreadyout), .stop_mode(stop_mode), .hv_on(hv_on),
    .bus_latched(bus_latched), .prog_mode(prog_mode));
`default_nettype wire
